// ===== rtl/flash_cmd_core.sv
`include "flash_cmd_consts.svh"

module flash_cmd_core #(
    parameter logic [7:0] MFR_ID = 8'h5a,  // Arbitrary value
    parameter logic [7:0] DEV_ID = 8'h3c   // Arbitrary value
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic [3:0]  io_in,
    output logic      [3:0]  io_out,
    output logic      [3:0]  io_oe,
    input  wire logic        write_in_progress_flag,
    input  wire logic        sw_reset,
    input  wire logic        rd_advance,
    input  wire logic [23:0] rd_addr_in,
    output logic      [23:0] rd_addr_next,
    output logic             wrap_disable_bit,
    output logic      [1:0]  wrap_length_field,
    output logic             power_down
);
    logic       cs_lvl;
    logic       cs_rise;
    logic       cs_fall;
    logic       sclk_rise;
    logic       sclk_fall;
    logic [3:0] io_lvl;

    pin_sync #(.W(1), .RST_VAL(8'h01)) u_cs (
        .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .pin(cs_n),
        .level(cs_lvl), .rise(cs_rise), .fall(cs_fall));
    pin_sync #(.W(1), .RST_VAL(8'h00)) u_sclk (
        .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .pin(sclk),
        .level(), .rise(sclk_rise), .fall(sclk_fall));
    pin_sync #(.W(4), .RST_VAL(8'h00)) u_io (
        .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .pin(io_in),
        .level(io_lvl), .rise(), .fall());

    // Rising edge after which data starts; mode and dummy clocks just pass
    function automatic logic [5:0] start_edge(input logic [7:0] op);
        case (op)
            `OP_RELEASE:   start_edge = `REL_ID_START;
            `OP_ID_SINGLE: start_edge = `ID1_START;
            `OP_ID_DUAL:   start_edge = `ID2_START;  // see R17
            `OP_ID_QUAD:   start_edge = `ID4_START;  // see R18
            default:       start_edge = `EDGE_CNT_MAX;
        endcase
    endfunction

    function automatic logic [2:0] lane_width(input logic [7:0] op);
        case (op)
            `OP_ID_DUAL: lane_width = 3'h2;
            `OP_ID_QUAD: lane_width = 3'h4;
            default:     lane_width = 3'h1;
        endcase
    endfunction

    function automatic logic [5:0] addr0_edge(input logic [7:0] op);
        case (op)
            `OP_ID_DUAL: addr0_edge = `ID2_ADDR0_EDGE;
            `OP_ID_QUAD: addr0_edge = `ID4_ADDR0_EDGE;
            default:     addr0_edge = `ID1_ADDR0_EDGE;
        endcase
    endfunction

    // Wrap mask arithmetic relies on 6-bit overflow: 8<<3 wraps to 0, minus 1 is 3f
    function automatic logic [23:0] step_addr(input logic [23:0] a, input logic dis,
                                              input logic [1:0] len);
        logic [5:0]  m;
        logic [23:0] inc;
        m   = (`WRAP_MIN_BYTES << len) - 6'h01;
        inc = a + 24'h000001;
        if (dis)
            step_addr = inc;
        else
            step_addr = {a[23:6], (a[5:0] & ~m) | (inc[5:0] & m)};
    endfunction

    flash_cmd_pkg::frame_t     phase;
    flash_cmd_pkg::frame_t     next_phase;
    flash_cmd_pkg::pwr_state_t pwr;
    flash_cmd_pkg::pwr_state_t next_pwr;
    logic [7:0]  opcode;
    logic [7:0]  next_opcode;
    logic [5:0]  edge_cnt;
    logic [5:0]  next_edge_cnt;
    logic [3:0]  wrap_nib;
    logic [3:0]  next_wrap_nib;
    logic        addr_lsb;
    logic        next_addr_lsb;
    logic [7:0]  out_sh;
    logic [7:0]  next_out_sh;
    logic [3:0]  out_left;
    logic [3:0]  next_out_left;
    logic        out_sel;
    logic        next_out_sel;
    logic [11:0] timer;
    logic [11:0] next_timer;
    logic [3:0]  next_io_out;
    logic [3:0]  next_io_oe;
    logic        next_wrap_disable_bit;
    logic [1:0]  next_wrap_length_field;
    logic [23:0] next_rd_addr_next;
    logic        wrap_commit;

    always_comb begin
        logic [5:0] cnt_inc;
        logic [7:0] op_in;
        logic [7:0] byte_now;
        logic [2:0] w;
        cnt_inc                = (edge_cnt == `EDGE_CNT_MAX) ? edge_cnt : edge_cnt + 6'h01;
        op_in                  = {opcode[6:0], io_lvl[0]};
        w                      = lane_width(opcode);
        byte_now               = out_sh;
        next_phase             = phase;
        next_pwr               = pwr;
        next_opcode            = opcode;
        next_edge_cnt          = edge_cnt;
        next_wrap_nib          = wrap_nib;
        next_addr_lsb          = addr_lsb;
        next_out_sh            = out_sh;
        next_out_left          = out_left;
        next_out_sel           = out_sel;
        next_timer             = timer;
        next_io_out            = io_out;
        next_io_oe             = io_oe;
        next_wrap_disable_bit  = wrap_disable_bit;
        next_wrap_length_field = wrap_length_field;
        next_rd_addr_next      = rd_addr_next;
        wrap_commit            = 1'b0;

        if (rd_advance)
            next_rd_addr_next = step_addr(rd_addr_in, wrap_disable_bit,
                                          wrap_length_field);  // see R05

        // Delay timers run regardless of the link
        if (pwr == flash_cmd_pkg::PWR_ENTERING || pwr == flash_cmd_pkg::PWR_RELEASING) begin
            if (timer == 12'h000)
                next_pwr = (pwr == flash_cmd_pkg::PWR_ENTERING) ?
                           flash_cmd_pkg::PWR_DOWN : flash_cmd_pkg::PWR_NORMAL;  // see R08
            else
                next_timer = timer - 12'h001;
        end

        if (cs_rise) begin
            next_phase = flash_cmd_pkg::FR_IDLE;  // see R20
            next_io_oe = 4'h0;
            if (phase != flash_cmd_pkg::FR_IGNORE && phase != flash_cmd_pkg::FR_IDLE) begin
                if (opcode == `OP_POWER_DOWN && edge_cnt == `OPCODE_EDGES &&
                    pwr == flash_cmd_pkg::PWR_NORMAL) begin
                    next_pwr   = flash_cmd_pkg::PWR_ENTERING;  // see R07
                    next_timer = 12'(`PD_ENTRY_CYC - 1);
                end
                if (opcode == `OP_RELEASE && pwr == flash_cmd_pkg::PWR_DOWN) begin
                    next_pwr   = flash_cmd_pkg::PWR_RELEASING;  // see R11
                    next_timer = (edge_cnt == `OPCODE_EDGES) ?
                                 12'(`RELEASE1_CYC - 1) : 12'(`RELEASE2_CYC - 1);  // see R13
                end
            end
        end else if (cs_fall) begin
            next_edge_cnt = 6'h00;
            next_opcode   = 8'h00;
            // No command is taken while an entry or release delay runs
            next_phase = (pwr == flash_cmd_pkg::PWR_ENTERING ||
                          pwr == flash_cmd_pkg::PWR_RELEASING) ?
                         flash_cmd_pkg::FR_IGNORE : flash_cmd_pkg::FR_OPCODE;  // see R11
        end else if (!cs_lvl && sclk_rise) begin
            next_edge_cnt = cnt_inc;  // see R20
            case (phase)
                flash_cmd_pkg::FR_OPCODE: begin
                    next_opcode = op_in;
                    if (cnt_inc == `OPCODE_EDGES) begin
                        if (pwr == flash_cmd_pkg::PWR_DOWN && op_in != `OP_RELEASE)
                            next_phase = flash_cmd_pkg::FR_IGNORE;  // see R09
                        else if (op_in == `OP_RELEASE && write_in_progress_flag)
                            next_phase = flash_cmd_pkg::FR_IGNORE;  // see R14
                        else if (op_in == `OP_SET_WRAP || op_in == `OP_POWER_DOWN ||
                                 op_in == `OP_RELEASE || op_in == `OP_ID_SINGLE ||
                                 op_in == `OP_ID_DUAL || op_in == `OP_ID_QUAD)
                            next_phase = flash_cmd_pkg::FR_BODY;
                        else
                            next_phase = flash_cmd_pkg::FR_IGNORE;
                    end
                end
                flash_cmd_pkg::FR_BODY: begin
                    if (opcode == `OP_SET_WRAP) begin
                        if (cnt_inc == `WRAP_NIB1_EDGE)
                            next_wrap_nib = io_lvl;  // see R01
                        if (cnt_inc == `WRAP_NIB2_EDGE) begin
                            wrap_commit            = 1'b1;
                            // Top bit of first nibble and whole second nibble dropped
                            next_wrap_disable_bit  = wrap_nib[0];  // see R02
                            next_wrap_length_field = wrap_nib[2:1];  // see R03 R04
                            next_phase             = flash_cmd_pkg::FR_IGNORE;
                        end
                    end else if (opcode == `OP_POWER_DOWN) begin
                        next_phase = flash_cmd_pkg::FR_IGNORE;  // see R07
                    end else begin
                        if (cnt_inc == addr0_edge(opcode))
                            next_addr_lsb = io_lvl[0];  // see R16 R19
                        if (cnt_inc == start_edge(opcode)) begin
                            next_phase    = flash_cmd_pkg::FR_OUTPUT;
                            next_out_left = 4'h0;
                            next_out_sel  = (opcode == `OP_RELEASE) ? 1'b1 :
                                            (opcode == `OP_ID_SINGLE) ? io_lvl[0] :
                                            next_addr_lsb;  // see R12 R15 R16
                        end
                    end
                end
                default: ;
            endcase
        end else if (!cs_lvl && sclk_fall && phase == flash_cmd_pkg::FR_OUTPUT) begin
            if (out_left == 4'h0) begin
                byte_now = out_sel ? DEV_ID : MFR_ID;
                if (opcode != `OP_RELEASE)
                    next_out_sel = ~out_sel;  // see R16
            end
            next_out_left = ((out_left == 4'h0) ? 4'h8 : out_left) - {1'b0, w};
            next_out_sh   = byte_now << w;
            case (w)
                3'h4: begin
                    next_io_out = byte_now[7:4];  // see R18
                    next_io_oe  = 4'hf;
                end
                3'h2: begin
                    next_io_out = {2'h0, byte_now[7:6]};  // see R17
                    next_io_oe  = 4'h3;
                end
                default: begin
                    next_io_out = {2'h0, byte_now[7], 1'b0};  // see R12 R15
                    next_io_oe  = 4'h2;
                end
            endcase
        end

        if (sw_reset)
            next_wrap_disable_bit = 1'b1;  // see R06
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phase             <= flash_cmd_pkg::FR_IDLE;
            pwr               <= flash_cmd_pkg::PWR_NORMAL;  // see R10
            opcode            <= 8'h00;
            edge_cnt          <= 6'h00;
            wrap_nib          <= 4'h0;
            addr_lsb          <= 1'b0;
            out_sh            <= 8'h00;
            out_left          <= 4'h0;
            out_sel           <= 1'b0;
            timer             <= 12'h000;
            io_out            <= 4'h0;
            io_oe             <= 4'h0;
            wrap_disable_bit  <= 1'b1;  // see R06
            wrap_length_field <= 2'h0;
            rd_addr_next      <= 24'h000000;
            power_down        <= 1'b0;
        end else if (clk_en) begin
            phase             <= next_phase;
            pwr               <= next_pwr;
            opcode            <= next_opcode;
            edge_cnt          <= next_edge_cnt;
            wrap_nib          <= next_wrap_nib;
            addr_lsb          <= next_addr_lsb;
            out_sh            <= next_out_sh;
            out_left          <= next_out_left;
            out_sel           <= next_out_sel;
            timer             <= next_timer;
            io_out            <= next_io_out;
            io_oe             <= next_io_oe;
            wrap_disable_bit  <= next_wrap_disable_bit;
            wrap_length_field <= next_wrap_length_field;
            rd_addr_next      <= next_rd_addr_next;
            power_down        <= (next_pwr == flash_cmd_pkg::PWR_DOWN ||
                                  next_pwr == flash_cmd_pkg::PWR_RELEASING);
        end
    end

    a_wrap_sw_reset: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && sw_reset) |=> wrap_disable_bit)  // see R06
        else $error("wrap not disabled after software reset");

    a_wrap_commit_bits: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && wrap_commit && !sw_reset) |=>
        (wrap_disable_bit == $past(wrap_nib[0]) &&
         wrap_length_field == $past(wrap_nib[2:1])))  // see R03
        else $error("wrap setting not stored from bits 6 to 4");

    a_wrap_section: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && rd_advance && !wrap_disable_bit && wrap_length_field == 2'h0) |=>
        (rd_addr_next[23:3] == $past(rd_addr_in[23:3]) &&
         rd_addr_next[2:0] == $past(rd_addr_in[2:0]) + 3'h1))  // see R05
        else $error("read address left its 8-byte section");

    a_pd_entry_done: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && pwr == flash_cmd_pkg::PWR_ENTERING && timer == 12'h000) |=>
        power_down)  // see R08
        else $error("power-down not reached at end of entry delay");

    a_pd_start_normal: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(rst) |-> (!power_down && pwr == flash_cmd_pkg::PWR_NORMAL))  // see R10
        else $error("device left reset powered down");

    a_pd_only_release: assert property (@(posedge clk_sys) disable iff (rst)
        (pwr == flash_cmd_pkg::PWR_DOWN && phase == flash_cmd_pkg::FR_BODY) |->
        opcode == `OP_RELEASE)  // see R09
        else $error("instruction other than release taken in power-down");

    a_release_quiet: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && cs_fall && pwr == flash_cmd_pkg::PWR_RELEASING) |=>
        phase == flash_cmd_pkg::FR_IGNORE)  // see R11
        else $error("command accepted during release delay");

    a_wip_blocks_release: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && phase == flash_cmd_pkg::FR_OPCODE && sclk_rise && !cs_lvl &&
         edge_cnt == 6'h07 && write_in_progress_flag &&
         {opcode[6:0], io_lvl[0]} == `OP_RELEASE) |=> phase == flash_cmd_pkg::FR_IGNORE)  // see R14
        else $error("release taken while write in progress");

    a_oe_off_at_cs: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && cs_rise) |=> (io_oe == 4'h0) [*2])  // see R20
        else $error("pins still driven after select rose");

    a_quad_lanes: assert property (@(posedge clk_sys) disable iff (rst)
        (io_oe != 4'h0 && opcode == `OP_ID_QUAD) |-> io_oe == 4'hf)  // see R18
        else $error("quad identifier read not on four lanes");
endmodule

// ===== include/flash_cmd_consts.svh
`ifndef FLASH_CMD_CONSTS_SVH
`define FLASH_CMD_CONSTS_SVH
// What this block does
// R01 - Wrap setting: opcode 77h, 24 don't-care bits, 8-bit setting byte, select low.
// R02 - Setting byte bit 7 and bits 3..0 are ignored; bits 6..4 matter.
// R03 - Disable bit 0: length field 00/01/10/11 gives 8/16/32/64 bytes in a page.
// R04 - Setting holds for later quad reads until rewritten; disable bit 1 returns linear.
// R05 - With wrap on, reads past the section end restart at its start.
// R06 - Wrap disable bit is 1 after power-on and after software reset.
// R07 - Power-down opcode B9h counts only if select rises right after its eighth bit.
// R08 - Valid power-down entry completes within the entry delay after select rises.
// R09 - In power-down only the release opcode ABh is recognised.
// R10 - Device always starts in normal operation, never powered down.
// R11 - ABh alone releases power-down; nothing accepted during the first release delay.
// R12 - ABh plus three dummy bytes streams the device identifier MSB first, repeating.
// R13 - Release with identifier readout waits the second release delay before resuming.
// R14 - ABh while a write is in progress is ignored.
// R15 - 90h plus 24-bit address streams manufacturer and device bytes MSB first.
// R16 - Address bit 0 picks the first byte; bytes alternate until select rises.
// R17 - 92h: address two bits per clock, four dummy clocks, data two bits per clock.
// R18 - 94h: address four bits per clock, six dummy clocks, data four bits per clock.
// R19 - Dual and quad identifier reads ignore the mode byte and upper address bits.
// R20 - Inputs sampled on rising clock; select low starts, select high ends each command.
`define OP_SET_WRAP      8'h77
`define OP_POWER_DOWN    8'hb9
`define OP_RELEASE       8'hab
`define OP_ID_SINGLE     8'h90
`define OP_ID_DUAL       8'h92
`define OP_ID_QUAD       8'h94
`define OPCODE_EDGES     6'h08
`define WRAP_NIB1_EDGE   6'h0f
`define WRAP_NIB2_EDGE   6'h10
`define REL_ID_START     6'h20
`define ID1_ADDR0_EDGE   6'h20
`define ID1_START        6'h20
`define ID2_ADDR0_EDGE   6'h14
`define ID2_START        6'h18
`define ID4_ADDR0_EDGE   6'h0e
`define ID4_START        6'h14
`define EDGE_CNT_MAX     6'h3f
`define WRAP_MIN_BYTES   6'h08
`define CLK_PERIOD_NS    40
`define PD_ENTRY_NS      3000
`define RELEASE1_NS      3000
`define RELEASE2_NS      8000
`define PD_ENTRY_CYC     (`PD_ENTRY_NS / `CLK_PERIOD_NS)
`define RELEASE1_CYC     (`RELEASE1_NS / `CLK_PERIOD_NS)
`define RELEASE2_CYC     (`RELEASE2_NS / `CLK_PERIOD_NS)
`endif

// ===== include/flash_cmd_pkg.sv
package flash_cmd_pkg;
    typedef enum logic [1:0] {PWR_NORMAL, PWR_ENTERING, PWR_DOWN, PWR_RELEASING} pwr_state_t;
    typedef enum logic [2:0] {FR_IDLE, FR_OPCODE, FR_BODY, FR_OUTPUT, FR_IGNORE} frame_t;
endpackage

// ===== rtl/pin_sync.sv
module pin_sync #(
    parameter int         W       = 1,
    parameter logic [7:0] RST_VAL = 8'h00
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [W-1:0] prev;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_stable;
    logic [W-1:0] next_prev;

    always_comb begin
        next_meta   = meta;
        next_stable = stable;
        next_prev   = prev;
        if (clk_en) begin
            next_meta   = pin;
            next_stable = meta;
            next_prev   = stable;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta   <= RST_VAL[W-1:0];
            stable <= RST_VAL[W-1:0];
            prev   <= RST_VAL[W-1:0];
        end else begin
            meta   <= next_meta;
            stable <= next_stable;
            prev   <= next_prev;
        end
    end

    // Edges come from the second and third stages only
    assign level = stable;
    assign rise  = stable & ~prev;
    assign fall  = ~stable & prev;
endmodule

// ===== tb/spi_host.sv
module spi_host (
    input  wire logic       clk_sys,
    output logic            cs_n,
    output logic            sclk,
    output logic      [3:0] io_in,
    input  wire logic [3:0] io_out,
    input  wire logic [3:0] io_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] hd;
    logic [3:0] rx;
    logic [3:0] oe_seen;

    // Device wins on every lane it enables
    assign io_in = (io_out & io_oe) | (hd & ~io_oe);

    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        hd = 4'h0;
        rx = 4'h0;
        oe_seen = 4'h0;
    end

    task automatic start();
        cs_n <= 1'b0;
        oe_seen <= 4'h0;
        repeat (4) @(posedge clk_sys);
    endtask

    // Data set while the clock is low, so it is stable at the rise
    task automatic clk(input logic [3:0] d);
        hd <= d;
        repeat (4) @(posedge clk_sys);
        rx = io_out;
        oe_seen <= oe_seen | io_oe;
        sclk <= 1'b1;
        repeat (4) @(posedge clk_sys);
        sclk <= 1'b0;
    endtask

    // Released lines flip so a stale value is never mistaken for data
    task automatic stop();
        repeat (4) @(posedge clk_sys);
        cs_n <= 1'b1;
        hd <= ~hd;
        repeat (4) @(posedge clk_sys);
    endtask
endmodule

// ===== tb/tb.sv
`include "flash_cmd_consts.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MFR = 8'hc5;  // Arbitrary value
    localparam logic [7:0] DEV = 8'h1e;  // Arbitrary value
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        clk_en = 1'b1;
    logic        cs_n;
    logic        sclk;
    logic [3:0]  io_in;
    logic [3:0]  io_out;
    logic [3:0]  io_oe;
    logic        busy = 1'b0;
    logic        sw_reset = 1'b0;
    logic        rd_advance = 1'b0;
    logic [23:0] rd_addr_in = 24'h0;
    logic [23:0] rd_addr_next;
    logic        wrap_disable_bit;
    logic [1:0]  wrap_length_field;
    logic        power_down;
    logic [31:0] seed = 32'h2323cc61;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          n;
    logic [23:0] a;
    logic [7:0]  w;

    always #20 clk_sys = ~clk_sys;

    flash_cmd_core #(.MFR_ID(MFR), .DEV_ID(DEV)) u_dut (
        .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .cs_n(cs_n), .sclk(sclk),
        .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .write_in_progress_flag(busy),
        .sw_reset(sw_reset), .rd_advance(rd_advance), .rd_addr_in(rd_addr_in),
        .rd_addr_next(rd_addr_next), .wrap_disable_bit(wrap_disable_bit),
        .wrap_length_field(wrap_length_field), .power_down(power_down));

    spi_host u_host (.clk_sys(clk_sys), .cs_n(cs_n), .sclk(sclk), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe));

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    function automatic logic [23:0] wrap_next(input logic [23:0] v, input logic [2:0] s);
        logic [23:0] m;
        m = (24'h8 << s[2:1]) - 24'h1;
        return s[0] ? v + 24'h1 : (v & ~m) | ((v + 24'h1) & m);
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic shift(input logic [31:0] v, input int e, input int l);
        for (int i = e - 1; i >= 0; i--) begin
            u_host.clk(4'((v >> (i * l)) & ((32'h1 << l) - 32'h1)));
        end
    endtask

    task automatic id_read(input logic [7:0] op, input int l, input logic [23:0] ad,
                           input logic [15:0] exp, input logic [3:0] eoe);
        logic [15:0] got;
        got = 16'h0;
        u_host.start();
        shift(32'(op), 8, 1);
        shift(op == 8'hab ? rnd() : 32'(ad), 24 / l, l);
        if (l > 1) shift(rnd(), l + 2, l);
        for (int i = 0; i < 16 / l; i++) begin
            u_host.clk(~u_host.hd);
            got = (got << l) | 16'(l == 1 ? {3'b0, u_host.rx[1]} : u_host.rx & 4'((1 << l) - 1));
        end
        u_host.stop();
        check("id_oe", 32'(u_host.oe_seen), 32'(eoe));
        if (eoe !== 4'h0) check("id_bytes", 32'(got), 32'(exp));
    endtask

    task automatic set_wrap(input logic [7:0] v);
        u_host.start();
        shift(32'h77, 8, 1);
        shift(rnd(), 6, 4);
        shift(32'(v), 2, 4);
        u_host.stop();
    endtask

    task automatic advance(input logic [23:0] v);
        rd_addr_in <= v;
        rd_advance <= 1'b1;
        @(posedge clk_sys);
        rd_advance <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Extra edges after the opcode spoil a power-down request
    task automatic pd_cmd(input logic [7:0] op, input int extra);
        u_host.start();
        shift(32'(op) << extra, 8 + extra, 1);
        u_host.stop();
    endtask

    task automatic wait_pd(input logic lvl, input int c, input string what);
        n = 0;
        while (power_down !== lvl) begin
            @(posedge clk_sys);
            n++;
            if (n > 500) begin
                error_cnt++;
                stop_test();
            end
        end
        check(what, 32'(n >= c - 8 && n <= c + 8), 32'h1);
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        check("wrap_disable", 32'(wrap_disable_bit), 32'h1);
        check("wrap_length", 32'(wrap_length_field), 32'h0);
        check("power_down", 32'(power_down), 32'h0);
        $display("test reset done");
        for (int k = 0; k < 6; k++) begin
            a = 24'(rnd());
            a[0] = k[0];
            n = 1 << (k / 2);
            id_read(8'h90 + 8'(k & 6), n, a, a[0] ? {DEV, MFR} : {MFR, DEV},
                    n == 1 ? 4'h2 : 4'((1 << n) - 1));
        end
        id_read(8'hab, 1, 24'h0, {DEV, DEV}, 4'h2);
        $display("test ident done");
        for (int l = 0; l < 5; l++) begin
            w = 8'(rnd());
            w[6:4] = l == 4 ? 3'b111 : {2'(l), 1'b0};
            a = 24'(rnd()) | (l[0] ? 24'h3f : 24'h0);
            set_wrap(w);
            check("wrap_disable", 32'(wrap_disable_bit), 32'(w[4]));
            check("wrap_length", 32'(wrap_length_field), 32'(w[6:5]));
            advance(a);
            check("rd_addr_next", 32'(rd_addr_next), 32'(wrap_next(a, w[6:4])));
        end
        set_wrap(8'h00);
        // A reset request while the enable is low must be lost
        clk_en   <= 1'b0;
        sw_reset <= 1'b1;
        @(posedge clk_sys);
        clk_en   <= 1'b1;
        sw_reset <= 1'b0;
        @(posedge clk_sys);
        check("wrap_frozen", 32'(wrap_disable_bit), 32'h0);
        sw_reset <= 1'b1;
        @(posedge clk_sys);
        sw_reset <= 1'b0;
        @(posedge clk_sys);
        check("wrap_disable", 32'(wrap_disable_bit), 32'h1);
        $display("test wrap done");
        pd_cmd(8'hb9, 1);
        repeat (`PD_ENTRY_CYC + 20) @(posedge clk_sys);
        check("power_down", 32'(power_down), 32'h0);
        pd_cmd(8'hb9, 0);
        wait_pd(1'b1, `PD_ENTRY_CYC, "pd_entry");
        id_read(8'h90, 1, 24'h0, 16'h0, 4'h0);
        busy <= 1'b1;
        pd_cmd(8'hab, 0);
        repeat (`RELEASE1_CYC + 20) @(posedge clk_sys);
        check("power_down", 32'(power_down), 32'h1);
        busy <= 1'b0;
        pd_cmd(8'hab, 0);
        wait_pd(1'b0, `RELEASE1_CYC, "release1");
        pd_cmd(8'hb9, 0);
        wait_pd(1'b1, `PD_ENTRY_CYC, "pd_entry");
        id_read(8'hab, 1, 24'h0, {DEV, DEV}, 4'h2);
        wait_pd(1'b0, `RELEASE2_CYC, "release2");
        // Frame started inside the release delay must be refused whole
        pd_cmd(8'hb9, 0);
        wait_pd(1'b1, `PD_ENTRY_CYC, "pd_entry");
        pd_cmd(8'hab, 0);
        id_read(8'h90, 1, 24'h1, 16'h0, 4'h0);
        check("power_down", 32'(power_down), 32'h0);
        $display("test power done");
        stop_test();
    end
endmodule
